// File: rtl/fmac_defines.svh
// Purpose: Constants for the fractional multiply-accumulate datapath
// Assumes: Included by bare name from rtl/
// Notes:   Widths, field positions, rounding constants, masks, limits and reset values only
`ifndef FMAC_DEFINES_SVH
`define FMAC_DEFINES_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define FMAC_OPND_W       24
`define FMAC_ACC_W        56
`define FMAC_PROD_W       48

// ----------------------------------------------------------------------
// Field positions inside an accumulator
// ----------------------------------------------------------------------
`define FMAC_EXT_MSB      55
`define FMAC_EXT_LSB      48
`define FMAC_UPPER_MSB    47
`define FMAC_UPPER_LSB    24
`define FMAC_LOWER_MSB    23
`define FMAC_LOWER_LSB    0

// ----------------------------------------------------------------------
// Rounding, masks and limits
// ----------------------------------------------------------------------
`define FMAC_RND_NORM     56'h00_000000_800000
`define FMAC_RND_HALF     56'h00_000080_000000
`define FMAC_KEEP_NORM    56'hFF_FFFFFF_000000
`define FMAC_KEEP_HALF    56'hFF_FFFF00_000000
`define FMAC_SRC_HALF     56'hFF_FFFF00_FFFF00
`define FMAC_OPND_HALF    24'hFFFF00
`define FMAC_POS_NORM     24'h7FFFFF
`define FMAC_NEG_NORM     24'h800000
`define FMAC_POS_HALF     24'h7FFF00
`define FMAC_NEG_HALF     24'h800000

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FMAC_ACC_RST      56'h00_000000_000000
`define FMAC_OPND_RST     24'h000000

`endif

// File: rtl/fmac_pkg.sv
// Purpose: Types for the fractional multiply-accumulate datapath
// Assumes: Compiled before every fmac module
// Notes:   Constants live in fmac_defines.svh
package fmac_pkg;

  // ----------------------------------------------------------------------
  // Operation and operand types
  // ----------------------------------------------------------------------
  typedef enum logic {
    FMAC_MPY,
    FMAC_MAC
  } fmac_kind_t;

  typedef enum logic {
    FMAC_ACC_FIRST,
    FMAC_ACC_SECOND
  } fmac_acc_sel_t;

  typedef logic [55:0] fmac_acc_t;
  typedef logic [23:0] fmac_opnd_t;

endpackage

// File: rtl/fmac_mult.sv
// Purpose: 24x24 fractional multiplier, signed/unsigned/mixed operands
// Assumes: Purely combinational; caller registers the result
// Notes:   Product is doubled (fractional) and sign-extended to 56 bits
`timescale 1ns/1ns
`include "fmac_defines.svh"

module fmac_mult
  import fmac_pkg::*;
(
  // Operands
  input  wire fmac_opnd_t a,
  input  wire fmac_opnd_t b,
  input  wire logic       a_signed,
  input  wire logic       b_signed,
  // Product
  output fmac_acc_t       prod
);

  // ----------------------------------------------------------------------
  // Multiply
  // ----------------------------------------------------------------------
  // One extra bit per operand lets a single signed multiplier cover
  // signed, unsigned and mixed cases
  logic signed [24:0] a_ext;
  logic signed [24:0] b_ext;
  logic signed [49:0] raw;

  assign a_ext = {a_signed & a[23], a};
  assign b_ext = {b_signed & b[23], b};
  assign raw   = a_ext * b_ext;
  // Fractional alignment: one left shift, right-justified in 56 bits
  assign prod  = {{5{raw[49]}}, raw, 1'b0};

endmodule

// File: rtl/fmac_top.sv
// Purpose: Two-stage fractional multiply-accumulate datapath, 24x24 -> 56
// Assumes: One core clock; operands come from registers on the same clock
// Notes:   Accumulators are internal and shown on read-only ports
//
// What this block does
// - Takes up to three operands, gives a 56-bit extension:upper:lower result.
// - Multiplies 24x24 fractionally with signed, unsigned or mixed operands.
// - Adds right-justified product to the selected first or second accumulator.
// - Delivers a 56-bit accumulator result as a 24-bit operand.
// - Truncates lower product by default, rounds only when the operation asks.
// - Two-cycle pipeline, one op per clock, back-to-back accumulator reuse.
// - In 16-bit mode the two sources are 16 bits wide and the accumulator 40.
`timescale 1ns/1ns
`include "fmac_defines.svh"

module fmac_top
  import fmac_pkg::*;
(
  // Clock and reset
  input  wire logic          CLK,
  input  wire logic          RSTN,
  // Operation request
  input  wire logic          OP_VALID,
  input  wire fmac_kind_t    OP_KIND,
  input  wire fmac_acc_sel_t OP_ACC_SEL,
  input  wire logic          OP_NEGATE,
  input  wire logic          OP_ROUND,
  input  wire logic          OP_SRC1_SIGNED,
  input  wire logic          OP_SRC2_SIGNED,
  input  wire fmac_opnd_t    OP_SRC1,
  input  wire fmac_opnd_t    OP_SRC2,
  // Arithmetic mode
  input  wire logic          MODE_16BIT,
  // Result
  output logic               RES_VALID,
  output fmac_acc_sel_t      RES_ACC_SEL,
  output fmac_acc_t          RES_ACC,
  output fmac_opnd_t         RES_OPERAND,
  output logic               RES_LIMITED,
  // Accumulator contents
  output fmac_acc_t          ACC_FIRST,
  output fmac_acc_t          ACC_SECOND
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  // Source accumulator view: in 16-bit mode only 40 bits take part
  function automatic fmac_acc_t src_view(input fmac_acc_t acc,
                                         input logic      half);
    src_view = half ? (acc & `FMAC_SRC_HALF) : acc;
  endfunction

  // Operand view: in 16-bit mode only the upper 16 bits take part
  function automatic fmac_opnd_t opnd_view(input fmac_opnd_t op,
                                           input logic       half);
    opnd_view = half ? (op & `FMAC_OPND_HALF) : op;
  endfunction

  // Reduce an accumulator to a stored operand, saturating on overflow
  // so a value that spilled into the extension does not wrap
  function automatic fmac_opnd_t to_operand(input fmac_acc_t acc,
                                            input logic      half);
    logic over;
    over = ~((&acc[`FMAC_EXT_MSB:`FMAC_UPPER_MSB]) |
             ~(|acc[`FMAC_EXT_MSB:`FMAC_UPPER_MSB]));
    if (!over) begin
      to_operand = half ?
        (acc[`FMAC_UPPER_MSB:`FMAC_UPPER_LSB] & `FMAC_OPND_HALF) :
        acc[`FMAC_UPPER_MSB:`FMAC_UPPER_LSB];
    end else if (acc[`FMAC_EXT_MSB]) begin
      to_operand = half ? `FMAC_NEG_HALF : `FMAC_NEG_NORM;
    end else begin
      to_operand = half ? `FMAC_POS_HALF : `FMAC_POS_NORM;
    end
  endfunction

  function automatic logic is_over(input fmac_acc_t acc);
    is_over = ~((&acc[`FMAC_EXT_MSB:`FMAC_UPPER_MSB]) |
                ~(|acc[`FMAC_EXT_MSB:`FMAC_UPPER_MSB]));
  endfunction

  // ----------------------------------------------------------------------
  // Stage 1: multiply
  // ----------------------------------------------------------------------
  fmac_acc_t     prod_c;
  fmac_acc_t     prod_reg;
  logic          s1_valid_reg;
  fmac_kind_t    s1_kind_reg;
  fmac_acc_sel_t s1_sel_reg;
  logic          s1_neg_reg;
  logic          s1_round_reg;
  logic          s1_half_reg;

  fmac_mult u_mult (
    .a        (opnd_view(OP_SRC1, MODE_16BIT)),
    .b        (opnd_view(OP_SRC2, MODE_16BIT)),
    .a_signed (OP_SRC1_SIGNED),
    .b_signed (OP_SRC2_SIGNED),
    .prod     (prod_c)
  );

  // A new operation is taken on every clock with OP_VALID high
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s1_valid_reg <= 1'b0;
    end else begin
      s1_valid_reg <= OP_VALID;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      prod_reg     <= `FMAC_ACC_RST;
      s1_kind_reg  <= FMAC_MPY;
      s1_sel_reg   <= FMAC_ACC_FIRST;
      s1_neg_reg   <= 1'b0;
      s1_round_reg <= 1'b0;
      s1_half_reg  <= 1'b0;
    end else if (OP_VALID) begin
      prod_reg     <= prod_c;
      s1_kind_reg  <= OP_KIND;
      s1_sel_reg   <= OP_ACC_SEL;
      s1_neg_reg   <= OP_NEGATE;
      s1_round_reg <= OP_ROUND;
      s1_half_reg  <= MODE_16BIT;
    end
  end

  // ----------------------------------------------------------------------
  // Stage 2: accumulate, round
  // ----------------------------------------------------------------------
  // The accumulator is read here, in the second stage, so a result
  // written one edge earlier is already visible: no stall is needed
  fmac_acc_t acc_first_reg;
  fmac_acc_t acc_second_reg;
  fmac_acc_t acc_src;
  fmac_acc_t addend;
  fmac_acc_t rnd_const;
  fmac_acc_t keep_mask;
  fmac_acc_t sum;
  fmac_acc_t acc_next;

  always_comb begin
    // Third operand: the selected accumulator, or zero for a multiply
    if (s1_kind_reg == FMAC_MAC) begin
      acc_src = src_view((s1_sel_reg == FMAC_ACC_SECOND) ?
                         acc_second_reg : acc_first_reg,
                         s1_half_reg);
    end else begin
      acc_src = `FMAC_ACC_RST;
    end
    addend = s1_neg_reg ? (~prod_reg + 56'h00_000000_000001) : prod_reg;
  end

  always_comb begin
    rnd_const = s1_half_reg ? `FMAC_RND_HALF : `FMAC_RND_NORM;
    keep_mask = s1_half_reg ? `FMAC_KEEP_HALF : `FMAC_KEEP_NORM;
    sum       = acc_src + addend;
    if (s1_round_reg) begin
      // Carry out of the half-LSB add ripples into upper and extension
      acc_next = (sum + rnd_const) & keep_mask;
    end else begin
      // Default keeps the full lower product; reduction truncates it
      acc_next = sum;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      acc_first_reg <= `FMAC_ACC_RST;
    end else if (s1_valid_reg && s1_sel_reg == FMAC_ACC_FIRST) begin
      acc_first_reg <= acc_next;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      acc_second_reg <= `FMAC_ACC_RST;
    end else if (s1_valid_reg && s1_sel_reg == FMAC_ACC_SECOND) begin
      acc_second_reg <= acc_next;
    end
  end

  // ----------------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------------
  fmac_acc_t     res_acc_reg;
  fmac_opnd_t    res_opnd_reg;
  fmac_acc_sel_t res_sel_reg;
  logic          res_valid_reg;
  logic          res_lim_reg;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      res_valid_reg <= 1'b0;
    end else begin
      res_valid_reg <= s1_valid_reg;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      res_acc_reg  <= `FMAC_ACC_RST;
      res_opnd_reg <= `FMAC_OPND_RST;
      res_sel_reg  <= FMAC_ACC_FIRST;
      res_lim_reg  <= 1'b0;
    end else if (s1_valid_reg) begin
      res_acc_reg  <= acc_next;
      res_opnd_reg <= to_operand(acc_next, s1_half_reg);
      res_sel_reg  <= s1_sel_reg;
      res_lim_reg  <= is_over(acc_next);
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign RES_VALID   = res_valid_reg;
  assign RES_ACC_SEL = res_sel_reg;
  assign RES_ACC     = res_acc_reg;
  assign RES_OPERAND = res_opnd_reg;
  assign RES_LIMITED = res_lim_reg;
  assign ACC_FIRST   = acc_first_reg;
  assign ACC_SECOND  = acc_second_reg;

endmodule

// File: dv/fmac_top_monitor.sv
// Purpose: Timing and arithmetic checks on the multiply-accumulate ports
// Assumes: Bound to fmac_top; sees its ports only
// Notes:   Results land two edges after the op is taken
`timescale 1ns/1ns
module fmac_top_monitor
  import fmac_pkg::*;
(
  // Clock and reset
  input wire logic          CLK,
  input wire logic          RSTN,
  // Operation request
  input wire logic          OP_VALID,
  input wire fmac_kind_t    OP_KIND,
  input wire fmac_acc_sel_t OP_ACC_SEL,
  input wire logic          OP_NEGATE,
  input wire logic          OP_ROUND,
  input wire logic          OP_SRC1_SIGNED,
  input wire logic          OP_SRC2_SIGNED,
  input wire fmac_opnd_t    OP_SRC1,
  input wire fmac_opnd_t    OP_SRC2,
  input wire logic          MODE_16BIT,
  // Result and accumulators
  input wire logic          RES_VALID,
  input wire fmac_acc_sel_t RES_ACC_SEL,
  input wire fmac_acc_t     RES_ACC,
  input wire fmac_opnd_t    RES_OPERAND,
  input wire logic          RES_LIMITED,
  input wire fmac_acc_t     ACC_FIRST,
  input wire fmac_acc_t     ACC_SECOND
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_two_cycle_answer: assert property (OP_VALID |-> ##2 RES_VALID)
    else $error("result pulse missing");
  a_dest_follows_sel: assert property (OP_VALID |-> ##2
    RES_ACC_SEL == $past(OP_ACC_SEL, 2)) else $error("wrong destination");
  a_first_gets_result: assert property (RES_VALID &&
    RES_ACC_SEL == FMAC_ACC_FIRST |-> ACC_FIRST == RES_ACC &&
    $stable(ACC_SECOND)) else $error("first accumulator not written");
  a_operand_view: assert property (RES_VALID &&
    !$past(MODE_16BIT, 2) && RES_ACC[55:47] inside {9'h000, 9'h1FF}
    |-> RES_OPERAND == RES_ACC[47:24] && !RES_LIMITED)
    else $error("operand view wrong");
  // Saturation keeps the sign so a clipped sample never flips polarity
  a_operand_limit: assert property (RES_VALID &&
    !(RES_ACC[55:47] inside {9'h000, 9'h1FF}) |-> RES_LIMITED &&
    RES_OPERAND[23:8] == (RES_ACC[55] ? 16'h8000 : 16'h7FFF))
    else $error("operand not limited");
  a_round_clears: assert property (OP_VALID && OP_ROUND &&
    !MODE_16BIT |-> ##2 RES_ACC[23:0] == 24'h000000)
    else $error("rounding left lower bits");
  a_half_round_clears: assert property (OP_VALID && OP_ROUND &&
    MODE_16BIT |-> ##2 RES_ACC[31:0] == 32'h00000000)
    else $error("16-bit rounding left lower bits");
  a_unsigned_product: assert property (OP_VALID &&
    OP_KIND == FMAC_MPY && !OP_NEGATE && !OP_ROUND && !OP_SRC1_SIGNED &&
    !OP_SRC2_SIGNED && !MODE_16BIT |-> ##2 RES_ACC ==
    ({32'h0, $past(OP_SRC1, 2)} * {32'h0, $past(OP_SRC2, 2)}) << 1)
    else $error("unsigned product wrong");
  a_half_low_zero: assert property (OP_VALID && MODE_16BIT |-> ##2
    RES_ACC[7:0] == 8'h00 && RES_OPERAND[7:0] == 8'h00)
    else $error("16-bit result low byte set");
endmodule

bind fmac_top fmac_top_monitor i_mon (.CLK, .RSTN, .OP_VALID, .OP_KIND,
  .OP_ACC_SEL, .OP_NEGATE, .OP_ROUND, .OP_SRC1_SIGNED, .OP_SRC2_SIGNED,
  .OP_SRC1, .OP_SRC2, .MODE_16BIT, .RES_VALID, .RES_ACC_SEL, .RES_ACC,
  .RES_OPERAND, .RES_LIMITED, .ACC_FIRST, .ACC_SECOND);

// File: dv/fmac_core_ctl.sv
// Purpose: Instruction controller model issuing data ALU operations
// Assumes: One operation per call, launched just after a rising edge
// Notes:   Idle operands toggle so stale values are never relied on
`timescale 1ns/1ns
module fmac_core_ctl
  import fmac_pkg::*;
(
  // Clock
  input  wire logic     CLK,
  // Operation request
  output logic          OP_VALID,
  output fmac_kind_t    OP_KIND,
  output fmac_acc_sel_t OP_ACC_SEL,
  output logic [3:0]    OP_FLAGS,
  output fmac_opnd_t    OP_SRC1,
  output fmac_opnd_t    OP_SRC2,
  output logic          MODE_16BIT
);
  // Enum outputs get their own literal, not a slice of a bit vector
  initial begin
    {OP_VALID, OP_FLAGS, MODE_16BIT} = '0;
    OP_KIND    = FMAC_MPY;
    OP_ACC_SEL = FMAC_ACC_FIRST;
    {OP_SRC1, OP_SRC2} = '0;
  end
  // Up to three operands: two sources and the accumulator
  task automatic issue(input fmac_kind_t k, input fmac_acc_sel_t s,
    input logic [3:0] f, input fmac_opnd_t a, b, input logic h);
    @(posedge CLK);
    OP_VALID   <= 1'b1;
    OP_KIND    <= k;
    OP_ACC_SEL <= s;
    OP_FLAGS   <= f;
    OP_SRC1    <= a;
    OP_SRC2    <= b;
    MODE_16BIT <= h;
  endtask
  task automatic idle;
    @(posedge CLK);
    OP_VALID <= 1'b0;
    OP_SRC1  <= ~OP_SRC1;
    OP_SRC2  <= ~OP_SRC2;
  endtask
endmodule

// File: dv/fmac_bench.sv
// Purpose: Self-checking bench for the multiply-accumulate datapath
// Assumes: Controller model drives every operation input
// Notes:   Expected results queue up and are judged on each result pulse
`timescale 1ns/1ns
module fmac_bench
  import fmac_pkg::*;
;
  logic CLK, RSTN, OP_VALID, MODE_16BIT, RES_VALID, RES_LIMITED;
  logic [3:0] flags;
  fmac_kind_t OP_KIND;
  fmac_acc_sel_t OP_ACC_SEL, RES_ACC_SEL;
  fmac_opnd_t OP_SRC1, OP_SRC2, RES_OPERAND;
  fmac_acc_t RES_ACC, ACC_FIRST, ACC_SECOND;
  fmac_acc_t acc_m [2];
  logic [80:0] q [$];
  int mismatches = 0;
  int cmp_count = 0;

  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  fmac_core_ctl i_ctl (.CLK(CLK), .OP_VALID(OP_VALID), .OP_KIND(OP_KIND),
    .OP_ACC_SEL(OP_ACC_SEL), .OP_FLAGS(flags), .OP_SRC1(OP_SRC1),
    .OP_SRC2(OP_SRC2), .MODE_16BIT(MODE_16BIT));
  fmac_top i_dut (.CLK(CLK), .RSTN(RSTN), .OP_VALID(OP_VALID),
    .OP_KIND(OP_KIND), .OP_ACC_SEL(OP_ACC_SEL), .OP_NEGATE(flags[3]),
    .OP_ROUND(flags[2]), .OP_SRC1_SIGNED(flags[1]),
    .OP_SRC2_SIGNED(flags[0]), .OP_SRC1(OP_SRC1), .OP_SRC2(OP_SRC2),
    .MODE_16BIT(MODE_16BIT), .RES_VALID(RES_VALID),
    .RES_ACC_SEL(RES_ACC_SEL), .RES_ACC(RES_ACC), .RES_OPERAND(RES_OPERAND),
    .RES_LIMITED(RES_LIMITED), .ACC_FIRST(ACC_FIRST),
    .ACC_SECOND(ACC_SECOND));

  task automatic check(input logic [80:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Result word is {limited, operand, accumulator}
  // Judged mid-cycle so no race with the edge that launches it
  always @(negedge CLK) begin
    if (RSTN && RES_VALID === 1'b1) begin
      if (q.size() == 0) check(81'h1, 81'h0);
      else check({RES_LIMITED, RES_OPERAND, RES_ACC}, q.pop_front());
    end
  end
  // Flags f are {negate, round, src1 signed, src2 signed}
  task automatic op(input fmac_kind_t k, input fmac_acc_sel_t s,
    input logic [3:0] f, input fmac_opnd_t a, b, input logic h);
    logic signed [55:0] x, y, sum;
    logic lim;
    fmac_opnd_t o;
    x = {{32{f[1] & a[23]}}, a[23:8], h ? 8'h00 : a[7:0]};
    y = {{32{f[0] & b[23]}}, b[23:8], h ? 8'h00 : b[7:0]};
    sum = (k == FMAC_MAC) ? acc_m[s] : '0;
    if (h) sum &= 56'hFF_FFFF00_FFFF00;
    sum = f[3] ? sum - ((x * y) <<< 1) : sum + ((x * y) <<< 1);
    if (f[2] && h)
      sum = (sum + 56'h00_000080_000000) & 56'hFF_FFFF00_000000;
    else if (f[2]) sum = (sum + 56'h800000) & 56'hFF_FFFFFF_000000;
    acc_m[s] = sum;
    lim = !(sum[55:47] inside {9'h000, 9'h1FF});
    o = h ? {sum[47:32], 8'h00} : sum[47:24];
    if (lim) o = sum[55] ? 24'h800000 : (h ? 24'h7FFF00 : 24'h7FFFFF);
    q.push_back({lim, o, sum});
    i_ctl.issue(k, s, f, a, b, h);
  endtask
  task automatic drain(input string name);
    i_ctl.idle();
    for (int i = 0; i < 20 && q.size() > 0; i++) @(negedge CLK);
    check(81'(q.size()), 81'h0);
    check(81'(ACC_FIRST), 81'(acc_m[0]));
    check(81'(ACC_SECOND), 81'(acc_m[1]));
    $display("%s done", name);
  endtask

  task automatic t_signs;
    for (int i = 0; i < 4; i++)
      op(FMAC_MPY, FMAC_ACC_FIRST, 4'(i), 24'h800001, 24'hC00003, 1'b0);
    drain("signs");
  endtask
  task automatic t_back_to_back;
    op(FMAC_MPY, FMAC_ACC_SECOND, 4'h3, 24'h400000, 24'h200000, 1'b0);
    op(FMAC_MAC, FMAC_ACC_SECOND, 4'hB, 24'h7FFFFF, 24'h000123, 1'b0);
    op(FMAC_MAC, FMAC_ACC_FIRST, 4'h1, 24'hFFFFFF, 24'h800000, 1'b0);
    drain("back_to_back");
  endtask
  task automatic t_round;
    op(FMAC_MPY, FMAC_ACC_FIRST, 4'h3, 24'h123457, 24'h0ABCDF, 1'b0);
    op(FMAC_MPY, FMAC_ACC_FIRST, 4'h7, 24'h123457, 24'h0ABCDF, 1'b0);
    op(FMAC_MAC, FMAC_ACC_FIRST, 4'hC, 24'h000FFF, 24'h000801, 1'b0);
    drain("round");
  endtask
  // Pushes past both operand limits to exercise saturation
  task automatic t_limit;
    for (int i = 0; i < 10; i++)
      op(FMAC_MAC, FMAC_ACC_SECOND, {i > 2, 3'h3}, 24'h7FFFFF, 24'h7FFFFF,
         1'b0);
    drain("limit");
  endtask
  task automatic t_half;
    op(FMAC_MAC, FMAC_ACC_FIRST, 4'h7, 24'h1234AB, 24'h80FFCD, 1'b1);
    op(FMAC_MAC, FMAC_ACC_FIRST, 4'h9, 24'hFFFFFF, 24'h7FFF11, 1'b1);
    for (int i = 0; i < 3; i++)
      op(FMAC_MAC, FMAC_ACC_SECOND, 4'h3, 24'h7FFF55, 24'h7FFFAA,
         1'b1);
    drain("half");
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    stop_test();
  end
  initial begin
    RSTN = 1'b0;
    acc_m = '{default: '0};
    repeat (10) @(posedge CLK);
    check(81'({RES_VALID, ACC_FIRST}), 81'h0);
    check(81'(ACC_SECOND), 81'h0);
    RSTN <= 1'b1;
    t_signs();
    t_back_to_back();
    t_round();
    t_limit();
    t_half();
    stop_test();
  end
endmodule
